//--- design/access_guard_pkg.sv
// constants and types shared by the memory access guard files
package access_guard_pkg;

  // --------------------------------------------------------------------
  // widths and depths
  // --------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int PROG_W = 14;
  localparam int PROG_DEPTH = 2048;
  localparam int PROG_AW = 11;
  localparam int EE_W = 8;
  localparam int EE_DEPTH = 256;
  localparam int EE_AW = 8;
  localparam int UID_COUNT = 4;
  localparam int UID_AW = 2;
  localparam int LIMIT_W = 12;
  localparam int PART_W = 9;
  localparam int STEP_W = 5;

  // --------------------------------------------------------------------
  // address map
  // --------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PROG_END = 16'h0800;
  localparam logic [7:0] EE_PAGE = 8'hf0;
  localparam logic [ADDR_W-1:0] UID_BASE = 16'h8000;
  localparam logic [ADDR_W-1:0] PART_ID_ADDR = 16'h8006;

  // --------------------------------------------------------------------
  // self-write guard size codes and first writable address
  // --------------------------------------------------------------------
  localparam logic [1:0] GUARD_NONE = 2'b11;
  localparam logic [1:0] GUARD_512 = 2'b10;
  localparam logic [1:0] GUARD_1K = 2'b01;
  localparam logic [1:0] GUARD_ALL = 2'b00;
  localparam logic [LIMIT_W-1:0] LIMIT_NONE = 12'h000;
  localparam logic [LIMIT_W-1:0] LIMIT_512 = 12'h200;
  localparam logic [LIMIT_W-1:0] LIMIT_1K = 12'h400;
  localparam logic [LIMIT_W-1:0] LIMIT_ALL = 12'h800;

  // --------------------------------------------------------------------
  // reset values: fully protected until the configuration is latched
  // --------------------------------------------------------------------
  localparam logic RST_CP_N = 1'b0;
  localparam logic RST_CPD_N = 1'b0;
  localparam logic [1:0] RST_GUARD = GUARD_ALL;
  localparam logic [PROG_W-1:0] RST_WORD = 14'h0000;
  localparam logic [EE_W-1:0] RST_BYTE = 8'h00;

  // --------------------------------------------------------------------
  // read data source of the previous read
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_ZERO = 3'b000,
    SRC_PROG = 3'b001,
    SRC_EE = 3'b010,
    SRC_CFG = 3'b011
  } src_t;

endpackage

//--- design/dual_port_mem.sv
// two-port synchronous memory with registered read data
`timescale 1ns/1ps
module dual_port_mem
  import access_guard_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic a_en,
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [W-1:0] a_wdata,
  output logic [W-1:0] a_rdata,
  input wire logic b_en,
  input wire logic b_we,
  input wire logic [AW-1:0] b_addr,
  input wire logic [W-1:0] b_wdata,
  output logic [W-1:0] b_rdata
);

  logic [W-1:0] cells [DEPTH];

  // port a is written last so it wins a same-address collision
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (b_en && b_we) begin
        cells[b_addr] <= b_wdata;
      end
      if (a_en && a_we) begin
        cells[a_addr] <= a_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      a_rdata <= '0;
      b_rdata <= '0;
    end else if (ce) begin
      if (a_en && !a_we) begin
        a_rdata <= cells[a_addr];
      end
      if (b_en && !b_we) begin
        b_rdata <= cells[b_addr];
      end
    end
  end

endmodule // dual_port_mem

//--- design/guard_limit_decode.sv
// maps the self-write guard size code to the first writable address
`timescale 1ns/1ps
module guard_limit_decode
  import access_guard_pkg::*;
(
  input wire logic [1:0] size,
  output logic [LIMIT_W-1:0] limit
);

  always_comb begin
    case (size)
      GUARD_NONE: limit = LIMIT_NONE;
      GUARD_512: limit = LIMIT_512;
      GUARD_1K: limit = LIMIT_1K;
      GUARD_ALL: limit = LIMIT_ALL;
      default: limit = LIMIT_ALL;
    endcase
  end

endmodule // guard_limit_decode

//--- design/memory_access_guard.sv
// protection gate between cpu, external programmer and the on-chip memories
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module memory_access_guard
  import access_guard_pkg::*;
#(
  // arbitrary identification values, not those of any real part
  parameter logic [PART_W-1:0] PART_CODE = 9'h0a5,
  parameter logic [STEP_W-1:0] SILICON_STEP = 5'h01
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic code_protect_n,
  input wire logic data_protect_n,
  input wire logic [1:0] self_write_guard_size,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [PROG_W-1:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [PROG_W-1:0] cpu_rdata,
  input wire logic [ADDR_W-1:0] ext_addr,
  input wire logic [PROG_W-1:0] ext_wdata,
  input wire logic ext_wr,
  input wire logic ext_rd,
  output logic [PROG_W-1:0] ext_rdata
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic loaded;
    logic cp_n;
    logic cpd_n;
    logic [1:0] guard;
    logic [UID_COUNT-1:0][PROG_W-1:0] uid;
    src_t cpu_src;
    src_t ext_src;
    logic [PROG_W-1:0] cpu_cfg;
    logic [PROG_W-1:0] ext_cfg;
  } guard_state_t;

  localparam guard_state_t STATE_RESET = '{
    loaded: 1'b0,
    cp_n: RST_CP_N,
    cpd_n: RST_CPD_N,
    guard: RST_GUARD,
    uid: '0,
    cpu_src: SRC_ZERO,
    ext_src: SRC_ZERO,
    cpu_cfg: RST_WORD,
    ext_cfg: RST_WORD
  };

  guard_state_t st;
  guard_state_t next_st;

  logic [PROG_W-1:0] part_word;
  logic [LIMIT_W-1:0] guard_limit;
  src_t cpu_region;
  src_t ext_region;
  logic prog_a_en;
  logic prog_a_we;
  logic prog_b_en;
  logic prog_b_we;
  logic ee_a_en;
  logic ee_a_we;
  logic ee_b_en;
  logic ee_b_we;
  logic [PROG_W-1:0] prog_a_rdata;
  logic [PROG_W-1:0] prog_b_rdata;
  logic [EE_W-1:0] ee_a_rdata;
  logic [EE_W-1:0] ee_b_rdata;

  assign part_word = {PART_CODE, SILICON_STEP};

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function automatic src_t region(input logic [ADDR_W-1:0] addr);
    if (addr < PROG_END) begin
      region = SRC_PROG;
    end else if (addr[ADDR_W-1:EE_AW] == EE_PAGE) begin
      region = SRC_EE;
    end else begin
      region = SRC_CFG;
    end
  endfunction

  function automatic logic is_uid(input logic [ADDR_W-1:0] addr);
    is_uid = (addr[ADDR_W-1:UID_AW] == UID_BASE[ADDR_W-1:UID_AW]);
  endfunction

  // unmapped configuration addresses read as zero
  function automatic logic [PROG_W-1:0] cfg_word(input logic [ADDR_W-1:0] addr,
      input logic [UID_COUNT-1:0][PROG_W-1:0] uid, input logic [PROG_W-1:0] part);
    if (is_uid(addr)) begin
      cfg_word = uid[addr[UID_AW-1:0]];
    end else if (addr == PART_ID_ADDR) begin
      cfg_word = part;
    end else begin
      cfg_word = RST_WORD;
    end
  endfunction

  assign cpu_region = region(cpu_addr);
  assign ext_region = region(ext_addr);

  guard_limit_decode u_limit (
    .size(st.guard),
    .limit(guard_limit)
  );

  // ----------------------------------------------------------------------
  // memory port gating
  // ----------------------------------------------------------------------
  // the cpu side ignores both protect bits; only the self-write guard applies
  assign prog_a_we = ce && cpu_wr && cpu_region == SRC_PROG &&
                     cpu_addr[LIMIT_W-1:0] >= guard_limit;
  assign prog_a_en = ce && cpu_region == SRC_PROG && (cpu_rd || prog_a_we);
  assign prog_b_we = ce && st.cp_n && ext_wr && ext_region == SRC_PROG;
  assign prog_b_en = ce && st.cp_n && ext_region == SRC_PROG && (ext_rd || ext_wr);
  assign ee_a_we = ce && cpu_wr && cpu_region == SRC_EE;
  assign ee_a_en = ce && cpu_region == SRC_EE && (cpu_rd || cpu_wr);
  assign ee_b_we = ce && st.cpd_n && ext_wr && ext_region == SRC_EE;
  assign ee_b_en = ce && st.cpd_n && ext_region == SRC_EE && (ext_rd || ext_wr);

  dual_port_mem #(
    .W(PROG_W),
    .DEPTH(PROG_DEPTH),
    .AW(PROG_AW)
  ) u_prog (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .a_en(prog_a_en),
    .a_we(prog_a_we),
    .a_addr(cpu_addr[PROG_AW-1:0]),
    .a_wdata(cpu_wdata),
    .a_rdata(prog_a_rdata),
    .b_en(prog_b_en),
    .b_we(prog_b_we),
    .b_addr(ext_addr[PROG_AW-1:0]),
    .b_wdata(ext_wdata),
    .b_rdata(prog_b_rdata)
  );

  dual_port_mem #(
    .W(EE_W),
    .DEPTH(EE_DEPTH),
    .AW(EE_AW)
  ) u_eeprom (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .a_en(ee_a_en),
    .a_we(ee_a_we),
    .a_addr(cpu_addr[EE_AW-1:0]),
    .a_wdata(cpu_wdata[EE_W-1:0]),
    .a_rdata(ee_a_rdata),
    .b_en(ee_b_en),
    .b_we(ee_b_we),
    .b_addr(ext_addr[EE_AW-1:0]),
    .b_wdata(ext_wdata[EE_W-1:0]),
    .b_rdata(ee_b_rdata)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // fuses are caught once, on the first enabled edge after reset release
    if (!st.loaded) begin
      next_st.loaded = 1'b1;
      next_st.cp_n = code_protect_n;
      next_st.cpd_n = data_protect_n;
      next_st.guard = self_write_guard_size;
    end
    if (cpu_rd) begin
      next_st.cpu_src = cpu_region;
      next_st.cpu_cfg = cfg_word(cpu_addr, st.uid, part_word);
    end
    if (ext_rd) begin
      next_st.ext_cfg = cfg_word(ext_addr, st.uid, part_word);
      case (ext_region)
        SRC_PROG: next_st.ext_src = st.cp_n ? SRC_PROG : SRC_ZERO;
        SRC_EE: next_st.ext_src = st.cpd_n ? SRC_EE : SRC_ZERO;
        SRC_CFG: next_st.ext_src = SRC_CFG;
        default: next_st.ext_src = SRC_ZERO;
      endcase
    end
    // the cpu write is applied last so it wins a collision on one word;
    // the identity word has no storage, so writes to it fall away
    if (ext_wr && ext_region == SRC_CFG && is_uid(ext_addr)) begin
      next_st.uid[ext_addr[UID_AW-1:0]] = ext_wdata;
    end
    if (cpu_wr && cpu_region == SRC_CFG && is_uid(cpu_addr)) begin
      next_st.uid[cpu_addr[UID_AW-1:0]] = cpu_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= STATE_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_comb begin
    case (st.cpu_src)
      SRC_PROG: cpu_rdata = prog_a_rdata;
      SRC_EE: cpu_rdata = {{(PROG_W-EE_W){1'b0}}, ee_a_rdata};
      SRC_CFG: cpu_rdata = st.cpu_cfg;
      default: cpu_rdata = RST_WORD;
    endcase
  end

  always_comb begin
    case (st.ext_src)
      SRC_PROG: ext_rdata = prog_b_rdata;
      SRC_EE: ext_rdata = {{(PROG_W-EE_W){1'b0}}, ee_b_rdata};
      SRC_CFG: ext_rdata = st.ext_cfg;
      default: ext_rdata = RST_WORD;
    endcase
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_uid_write;
    ce && cpu_wr && is_uid(cpu_addr) && !ext_wr;
  endsequence

  sequence s_same_read;
    ce && cpu_rd && cpu_addr == $past(cpu_addr) && !ext_wr;
  endsequence

  a_prog_read_zero: assert property (
    ce && st.loaded && ext_rd && ext_region == SRC_PROG && !st.cp_n |=> ext_rdata == RST_WORD)
    else $error("protected program read did not return zero");

  a_prog_write_drop: assert property (
    ext_wr && ext_region == SRC_PROG && !st.cp_n |-> !prog_b_we && !prog_b_en)
    else $error("protected external program write reached memory");

  a_cpu_fetch_pass: assert property (
    ce && cpu_rd && cpu_region == SRC_PROG |-> prog_a_en ##1 st.cpu_src == SRC_PROG)
    else $error("cpu program read was blocked");

  a_split_protect: assert property (
    ce && st.loaded && ext_rd && ext_region == SRC_EE && st.cpd_n && !st.cp_n
    |=> st.ext_src == SRC_EE)
    else $error("program protection leaked onto eeprom");

  a_ee_ext_refuse: assert property (
    ce && st.loaded && (ext_rd || ext_wr) && ext_region == SRC_EE && !st.cpd_n
    |-> !ee_b_en ##1 (!$past(ext_rd) || ext_rdata == RST_WORD))
    else $error("protected eeprom access was not refused");

  a_cpu_ee_write: assert property (
    ce && cpu_wr && cpu_region == SRC_EE |-> ee_a_we && ee_a_en)
    else $error("cpu eeprom write was blocked");

  a_self_write_guard: assert property (
    ce && cpu_wr && cpu_region == SRC_PROG
    |-> prog_a_we == (st.guard == GUARD_NONE ||
                      (st.guard == GUARD_512 && cpu_addr[LIMIT_W-1:0] >= LIMIT_512) ||
                      (st.guard == GUARD_1K && cpu_addr[LIMIT_W-1:0] >= LIMIT_1K)))
    else $error("self-write guard decision wrong");

  a_guard_sizes: assert property (
    (st.guard == GUARD_512 |-> guard_limit == LIMIT_512) and
    (st.guard == GUARD_NONE |-> guard_limit == LIMIT_NONE) and
    (st.guard == GUARD_1K |-> guard_limit == LIMIT_1K) and
    (st.guard == GUARD_ALL |-> guard_limit == LIMIT_ALL))
    else $error("guard size decode wrong");

  a_uid_round_trip: assert property (
    s_uid_write ##1 (!cpu_wr && !ext_wr) ##1 s_same_read |=> cpu_rdata == $past(cpu_wdata, 3))
    else $error("user id word did not read back");

  a_part_word_read: assert property (
    ce && ext_rd && ext_addr == PART_ID_ADDR |=> ext_rdata == {PART_CODE, SILICON_STEP})
    else $error("external part identity read wrong");

  a_part_word_fixed: assert property (
    ce && cpu_wr && cpu_addr == PART_ID_ADDR ##2 ce && cpu_rd && cpu_addr == PART_ID_ADDR
    |=> cpu_rdata[STEP_W-1:0] == SILICON_STEP && cpu_rdata[PROG_W-1:STEP_W] == PART_CODE)
    else $error("part identity word changed after write");

endmodule // memory_access_guard

//--- testbench/ext_programmer.sv
// behavioural external programmer driving the guard's external port
`timescale 1ns/1ps
module ext_programmer
  import access_guard_pkg::*;
(
  input wire logic mclk,
  output logic [ADDR_W-1:0] ext_addr,
  output logic [PROG_W-1:0] ext_wdata,
  output logic ext_wr,
  output logic ext_rd,
  input wire logic [PROG_W-1:0] ext_rdata
);
  initial begin
    ext_addr = 16'h0000;
    ext_wdata = 14'h0000;
    ext_wr = 1'h0;
    ext_rd = 1'h0;
  end

  // -------------------------------------------------------------
  // transfers: enter right after a rising edge, leave on one
  // -------------------------------------------------------------
  // write data is inverted once taken so stale data never looks valid
  task automatic put(input logic [ADDR_W-1:0] a, input logic [PROG_W-1:0] d);
    ext_addr <= a;
    ext_wdata <= d;
    ext_wr <= 1'h1;
    @(posedge mclk);
    ext_wr <= 1'h0;
    ext_wdata <= ~d;
    @(posedge mclk);
  endtask

  task automatic get(input logic [ADDR_W-1:0] a, output logic [PROG_W-1:0] d);
    ext_addr <= a;
    ext_rd <= 1'h1;
    @(posedge mclk);
    ext_rd <= 1'h0;
    @(negedge mclk);
    d = ext_rdata;
    @(posedge mclk);
  endtask
endmodule // ext_programmer

//--- testbench/test_memory_access_guard.sv
// self-checking testbench of the memory access guard
`timescale 1ns/1ps
module test_memory_access_guard;
  import access_guard_pkg::*;
  // arbitrary identification values
  localparam logic [PART_W-1:0] TB_PART = 9'h0c3;
  localparam logic [STEP_W-1:0] TB_STEP = 5'h0a;
  logic mclk, rst, ce, code_protect_n, data_protect_n, cpu_wr, cpu_rd, ext_wr, ext_rd;
  logic [1:0] self_write_guard_size;
  logic [ADDR_W-1:0] cpu_addr, ext_addr;
  logic [PROG_W-1:0] cpu_wdata, cpu_rdata, ext_wdata, ext_rdata, v;
  logic [EE_W-1:0] d8;
  logic [PROG_W-1:0] pm [int];
  logic [EE_W-1:0] ee [int];
  logic [1:0] fuse_tbl [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  logic [1:0] guard_tbl [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  int limit_tbl [4] = '{0, 'h200, 'h400, 'h800};
  int seeds [6] = '{0, 'h1ff, 'h200, 'h3ff, 'h400, 'h7ff};
  int error_cnt = 0;
  int n_checks = 0;
  int lim;

  memory_access_guard #(.PART_CODE(TB_PART), .SILICON_STEP(TB_STEP)) i_memory_access_guard (
    .mclk(mclk), .rst(rst), .ce(ce), .code_protect_n(code_protect_n),
    .data_protect_n(data_protect_n), .self_write_guard_size(self_write_guard_size),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_wr(ext_wr),
    .ext_rd(ext_rd), .ext_rdata(ext_rdata));

  ext_programmer i_ext_programmer (
    .mclk(mclk), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_wr(ext_wr),
    .ext_rd(ext_rd), .ext_rdata(ext_rdata));

  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic end_sim;
    $display("errors=%0d checks=%0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [PROG_W-1:0] seen,
                       input logic [PROG_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cpu_put(input logic [ADDR_W-1:0] a, input logic [PROG_W-1:0] d);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'h1;
    @(posedge mclk);
    cpu_wr <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic cpu_get(input logic [ADDR_W-1:0] a, output logic [PROG_W-1:0] d);
    cpu_addr <= a;
    cpu_rd <= 1'h1;
    @(posedge mclk);
    cpu_rd <= 1'h0;
    @(negedge mclk);
    d = cpu_rdata;
    @(posedge mclk);
  endtask

  // fuses are latched once after release, so each setting needs a reset
  task automatic do_reset(input logic [1:0] fuse, input logic [1:0] guard);
    @(posedge mclk);
    rst <= 1'h1;
    code_protect_n <= fuse[1];
    data_protect_n <= fuse[0];
    self_write_guard_size <= guard;
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    repeat (2) @(posedge mclk);
  endtask

  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    rst = 1'h1;
    ce = 1'h1;
    code_protect_n = 1'h1;
    data_protect_n = 1'h1;
    self_write_guard_size = 2'h3;
    cpu_addr = 16'h0000;
    cpu_wdata = 14'h0000;
    cpu_wr = 1'h0;
    cpu_rd = 1'h0;
    for (int p = 0; p < 4; p++) begin
      do_reset(fuse_tbl[p], guard_tbl[p]);
      if (p == 0) begin
        for (int i = 0; i < 6; i++) begin
          pm[seeds[i]] = PROG_W'(14'h0100 + i);
          i_ext_programmer.put(ADDR_W'(seeds[i]), pm[seeds[i]]);
          i_ext_programmer.get(ADDR_W'(seeds[i]), v);
          check("ext program word", v, pm[seeds[i]]);
        end
      end
      i_ext_programmer.get(16'h0200, v);
      check("ext program read", v, fuse_tbl[p][1] ? pm['h200] : 14'h0000);
      i_ext_programmer.put(16'h07ff, PROG_W'(14'h1000 + p));
      if (fuse_tbl[p][1]) pm['h7ff] = PROG_W'(14'h1000 + p);
      cpu_get(16'h07ff, v);
      check("cpu program read", v, pm['h7ff]);
      d8 = EE_W'(8'h40 + p);
      i_ext_programmer.put(16'hf005, {6'h00, d8});
      if (fuse_tbl[p][0]) ee['h05] = d8;
      i_ext_programmer.get(16'hf005, v);
      check("ext eeprom read", v, fuse_tbl[p][0] ? {6'h00, ee['h05]} : 14'h0000);
      cpu_get(16'hf005, v);
      check("cpu eeprom read", v, {6'h00, ee['h05]});
      cpu_put(16'hf006, PROG_W'(14'h0050 + p));
      cpu_get(16'hf006, v);
      check("cpu eeprom write", v, PROG_W'(14'h0050 + p));
      lim = limit_tbl[p];
      if (lim > 0) begin
        cpu_put(ADDR_W'(lim - 1), PROG_W'(14'h2000 + p));
        cpu_get(ADDR_W'(lim - 1), v);
        check("guarded word", v, pm[lim - 1]);
      end
      if (lim < 'h800) begin
        pm[lim] = PROG_W'(14'h2100 + p);
        cpu_put(ADDR_W'(lim), pm[lim]);
        cpu_get(ADDR_W'(lim), v);
        check("open word", v, pm[lim]);
      end
      cpu_put(PART_ID_ADDR, 14'h3fff);
      cpu_get(PART_ID_ADDR, v);
      check("cpu part identity", v, {TB_PART, TB_STEP});
      i_ext_programmer.get(PART_ID_ADDR, v);
      check("ext part identity", v, {TB_PART, TB_STEP});
      cpu_put(UID_BASE + ADDR_W'(p), PROG_W'(14'h0500 + p));
      cpu_get(UID_BASE + ADDR_W'(p), v);
      check("cpu user id", v, PROG_W'(14'h0500 + p));
      i_ext_programmer.get(UID_BASE + ADDR_W'(p), v);
      check("user id word", v, PROG_W'(14'h0500 + p));
      // a write while the clock enable is low must leave the word alone
      if (p == 0) begin
        ce <= 1'h0;
        cpu_put(UID_BASE, 14'h0aaa);
        ce <= 1'h1;
        cpu_get(UID_BASE, v);
        check("frozen user id", v, 14'h0500);
      end
    end
    end_sim;
  end

  // run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    end_sim;
  end
endmodule // test_memory_access_guard
